// file: rtl/cwp_pkg.sv
// Shared constants, types and the address map of the current-input word packer.
package cwp_pkg;

	// ------------------------------------------------------------
	// Clock and publishing period
	// ------------------------------------------------------------
	localparam longint CLK_HZ           = 25_000_000;
	localparam longint UPDATE_PERIOD_NS = 6_500_000;
	// Longest allowed period, so the cycle count rounds down.
	localparam int UPDATE_CYCLES =
		int'((UPDATE_PERIOD_NS * CLK_HZ) / 64'd1_000_000_000);

	// ------------------------------------------------------------
	// Channel word layout
	// ------------------------------------------------------------
	localparam int MEAS_W         = 12;
	localparam int WORD_W         = 16;
	localparam int MEAS_LSB       = 4;
	localparam int LIVE_ZERO_BIT  = 0;
	localparam int LINE_FAULT_BIT = 1;

	// Scaling window inside which the status nibble is kept.
	localparam logic [15:0] SCALE_MIN = 16'h2710;
	localparam logic [15:0] SCALE_MAX = 16'hC350;

	// Converter codes: 0..4095 span 0..25 mA.
	localparam logic [11:0] LIVE_ZERO_CODE = 12'h024E;
	localparam logic [11:0] BREAK_DEFAULT  = 12'h00A3;
	localparam logic [11:0] SHORT_DEFAULT  = 12'h0D70;

	// ------------------------------------------------------------
	// Direct offsets of the areas
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_ALLOC_PROC = 16'h0000;
	localparam logic [15:0] OFS_SLOT_PROC  = 16'h0100;
	localparam logic [15:0] OFS_SLOT_STAT  = 16'h0300;
	localparam logic [15:0] OFS_SLOT_TYPE  = 16'h0400;
	localparam logic [15:0] OFS_HOLD_PROC  = 16'h0600;
	localparam logic [15:0] OFS_STAT_BITS  = 16'h0800;

	// Conventional register numbers of the same areas.
	localparam logic [15:0] CONV_INPUT     = 16'h7531;
	localparam logic [15:0] CONV_SLOT_PROC = 16'h88B8;
	localparam logic [15:0] CONV_SLOT_STAT = 16'h8980;
	localparam logic [15:0] CONV_SLOT_TYPE = 16'h89E4;
	localparam logic [15:0] CONV_HOLD_PROC = 16'h3F48;
	localparam logic [15:0] CONV_STAT_BITS = 16'h36B1;

	// ------------------------------------------------------------
	// Function and exception codes
	// ------------------------------------------------------------
	localparam logic [7:0] FC_READ_BITS  = 8'h02;
	localparam logic [7:0] FC_READ_HOLD  = 8'h03;
	localparam logic [7:0] FC_READ_INPUT = 8'h04;
	localparam logic [7:0] EXC_NONE      = 8'h00;
	localparam logic [7:0] EXC_BAD_FUNC  = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDR  = 8'h02;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_DECODE = 2'b01,
		ST_ANSWER = 2'b11
	} cwp_state_e;

	typedef struct packed {
		logic [7:0]  func;
		logic [15:0] addr;
		logic        conventional;
	} cwp_req_s;

	typedef struct packed {
		logic [15:0] data;
		logic [7:0]  exc;
	} cwp_rsp_s;

endpackage

// file: rtl/cwp_word_packer.sv
// Combinational packing of one converter sample into the channel word.
`timescale 1ns/1ps
module cwp_word_packer
	import cwp_pkg::*;
(
	// Sample.
	input  wire logic [MEAS_W-1:0] sampleCode,
	// Configuration.
	input  wire logic              lineFaultEnable,
	input  wire logic [MEAS_W-1:0] breakCode,
	input  wire logic [MEAS_W-1:0] shortCode,
	input  wire logic [15:0]       scaleBegin,
	input  wire logic [15:0]       scaleEnd,
	// Result.
	output logic [WORD_W-1:0]      word,
	output logic                   liveZero,
	output logic                   lineFault
);

	logic statusKept;

	// Fault flags; a disabled detector never reports.
	always_comb begin
		liveZero  = sampleCode < LIVE_ZERO_CODE;
		lineFault = lineFaultEnable &&
			(sampleCode < breakCode || sampleCode > shortCode);
	end

	// Status survives only inside the scaling window.
	assign statusKept = scaleBegin >= SCALE_MIN && scaleEnd <= SCALE_MAX;

	// Measured value in the top twelve bits, status in the low nibble.
	always_comb begin
		word = {sampleCode, 4'h0};
		if (statusKept) begin
			word[LIVE_ZERO_BIT]  = liveZero;
			word[LINE_FAULT_BIT] = lineFault;
		end
	end

endmodule

// file: rtl/cwp_current_input.sv
// Current-input channel: word packing, periodic publish and read access.
`timescale 1ns/1ps
module cwp_current_input
	import cwp_pkg::*;
#(
	parameter int          UPDATE_COUNT = UPDATE_CYCLES,
	parameter logic [15:0] SLOT         = 16'h0000,
	// Arbitrary neutral value for the type word.
	parameter logic [15:0] TYPE_CODE    = 16'h00A5
)(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst,
	// Converter samples, already twelve bits over 0 to 25 mA.
	input  wire logic [MEAS_W-1:0] sampleCode,
	input  wire logic              sampleValid,
	// Channel configuration.
	input  wire logic              lineFaultEnable,
	input  wire logic [MEAS_W-1:0] breakCode,
	input  wire logic [MEAS_W-1:0] shortCode,
	input  wire logic [15:0]       scaleBegin,
	input  wire logic [15:0]       scaleEnd,
	input  wire logic [15:0]       allocAddr,
	// Master requests.
	input  wire cwp_req_s          req,
	input  wire logic              reqValid,
	output logic                   reqReady,
	// Answers.
	output cwp_rsp_s               rsp,
	output logic                   rspValid,
	// Published state.
	output logic [WORD_W-1:0]      channelWord,
	output logic                   publishPulse
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// The period counter is 24 bits wide; a longer period would have its
	// end value cut to 24 bits, and the word would be published too often.
	if (UPDATE_COUNT < 1 || UPDATE_COUNT > 32'h00FF_FFFF) begin : g_count
		$error("UPDATE_COUNT out of range");
	end

	// Eight status bits per slot must stay inside the bit area, and
	// the slot is shifted by three before it is added.
	if (SLOT > 16'h00FF) begin : g_slot
		$error("SLOT must fit in eight bits");
	end

	// The packer puts the code directly above the status nibble.
	if (MEAS_W + MEAS_LSB != WORD_W) begin : g_layout
		$error("Word layout does not add up");
	end

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------

	// Map a conventional number onto the direct offset of its area.
	// The conventional bases are not one fixed distance from the direct
	// ones, so each area is recognised by the highest base at or below
	// the number. Bit 16 of the result flags a number below every base
	// of its function; the decoder answers that with an address error.
	function automatic logic [16:0] toDirect(input logic [7:0] fc,
	                                         input logic [15:0] a);
		logic [16:0] d;
		d = {1'b1, 16'h0000};
		if (fc == FC_READ_INPUT) begin
			if (a >= CONV_SLOT_TYPE)
				d = {1'b0, a - CONV_SLOT_TYPE + OFS_SLOT_TYPE};
			else if (a >= CONV_SLOT_STAT)
				d = {1'b0, a - CONV_SLOT_STAT + OFS_SLOT_STAT};
			else if (a >= CONV_SLOT_PROC)
				d = {1'b0, a - CONV_SLOT_PROC + OFS_SLOT_PROC};
			else if (a >= CONV_INPUT)
				d = {1'b0, a - CONV_INPUT + OFS_ALLOC_PROC};
		end else if (fc == FC_READ_HOLD) begin
			if (a >= CONV_HOLD_PROC)
				d = {1'b0, a - CONV_HOLD_PROC + OFS_HOLD_PROC};
		end else if (fc == FC_READ_BITS) begin
			if (a >= CONV_STAT_BITS)
				d = {1'b0, a - CONV_STAT_BITS + OFS_STAT_BITS};
		end
		return d;
	endfunction

	// True when an address hits base plus index exactly.
	// The sum wraps at sixteen bits, as the address itself does.
	function automatic logic hits(input logic [15:0] a,
	                              input logic [15:0] base,
	                              input logic [15:0] idx);
		return a == 16'(base + idx);
	endfunction

	// ------------------------------------------------------------
	// Sample capture and packing
	// ------------------------------------------------------------
	logic [MEAS_W-1:0] heldCode;
	logic [WORD_W-1:0] packedWord;
	logic              liveZero;
	logic              lineFault;

	// Keep the newest conversion; the converter runs slower than publish.
	// A sample that arrives between two publishes waits here, so every
	// published word carries a whole code, never a mix of two.
	always_ff @(posedge clk) begin
		if (rst)
			heldCode <= '0;
		else if (sampleValid)
			heldCode <= sampleCode;
	end

	cwp_word_packer packer (
		.sampleCode      (heldCode),
		.lineFaultEnable (lineFaultEnable),
		.breakCode       (breakCode),
		.shortCode       (shortCode),
		.scaleBegin      (scaleBegin),
		.scaleEnd        (scaleEnd),
		.word            (packedWord),
		.liveZero        (liveZero),
		.lineFault       (lineFault)
	);

	// ------------------------------------------------------------
	// Periodic publish
	// ------------------------------------------------------------
	logic [23:0] periodCount;
	logic [7:0]  statusByte;
	logic        periodEnd;

	// The last count of a period; the first publish after reset falls
	// on the edge UPDATE_COUNT cycles after release, then every
	// UPDATE_COUNT cycles without drift.
	assign periodEnd = periodCount == 24'(UPDATE_COUNT - 1);

	// Free-running period counter, independent of the converter pace.
	// Requests never stall it, so reads cannot skew the publish rate.
	always_ff @(posedge clk) begin
		if (rst)
			periodCount <= '0;
		else if (periodEnd)
			periodCount <= '0;
		else
			periodCount <= periodCount + 24'h0000_01;
	end

	// Word and module status change only at a period boundary, so a
	// master never sees a half-updated pair.
	always_ff @(posedge clk) begin
		if (rst) begin
			channelWord  <= 16'h0000;
			statusByte   <= 8'h00;
			publishPulse <= 1'b0;
		end else begin
			publishPulse <= periodEnd;
			if (periodEnd) begin
				channelWord <= packedWord;
				statusByte  <= {6'h00, lineFault, liveZero};
			end
		end
	end

	// ------------------------------------------------------------
	// Request handling
	// ------------------------------------------------------------
	// Timing of one read, counted in rising edges:
	//   edge 0: reqValid seen while idle, request captured, ready drops;
	//   edge 1: answer registered, rspValid high for one cycle;
	//   edge 2: back to idle, ready high again.
	// A strobe while ready is low is ignored, so a master must hold its
	// request until ready is seen high. At most one read every three
	// cycles; the published word changes faster than that only when UPDATE_COUNT is below three.
	//
	// Read map, direct offsets:
	//   function 4: allocated word, slot word, slot status, slot type;
	//   function 3: allocated word in the holding area;
	//   function 2: the eight module status bits of this slot.
	// Anything else, writes included, answers with an exception.

	cwp_state_e  state;
	cwp_state_e  next_state;
	cwp_req_s    held;
	logic [16:0] direct;
	logic [15:0] statusWord;
	logic [15:0] next_data;
	logic [7:0]  next_exc;
	logic [15:0] bitIdx;

	// The module status byte sits in the high byte of its word. Unlike
	// the channel word it keeps both fault flags even when the scaling
	// window drops them from the nibble.
	assign statusWord = {statusByte, 8'h00};

	// Both numberings collapse onto the direct offsets here.
	assign direct = held.conventional ?
		toDirect(held.func, held.addr) : {1'b0, held.addr};

	// Bit number, counted from zero, inside this slot's eight status bits. An
	// address below the slot wraps to a large value and is refused.
	assign bitIdx = direct[15:0] - OFS_STAT_BITS - {SLOT[12:0], 3'b000};

	// Sequencer: one request in flight; the answer follows on the next
	// edge and the extra answer state keeps ready low for its cycle.
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (reqValid)
					next_state = ST_DECODE;
			ST_DECODE:
				next_state = ST_ANSWER;
			ST_ANSWER:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Capture the request only while idle; later ones are not taken.
	always_ff @(posedge clk) begin
		if (rst)
			held <= '0;
		else if (state == ST_IDLE && reqValid)
			held <= req;
	end

	// Address decode for the three read functions. The allocated word is
	// tried first, so an allocated address that overlaps a slot area
	// shadows that slot entry.
	always_comb begin
		next_data = 16'h0000;
		next_exc  = EXC_NONE;
		if (direct[16]) begin
			next_exc = EXC_BAD_ADDR;
		end else if (held.func == FC_READ_INPUT) begin
			if (hits(direct[15:0], OFS_ALLOC_PROC, allocAddr))
				next_data = channelWord;
			else if (hits(direct[15:0], OFS_SLOT_PROC, SLOT))
				next_data = channelWord;
			else if (hits(direct[15:0], OFS_SLOT_STAT, SLOT))
				next_data = statusWord;
			else if (hits(direct[15:0], OFS_SLOT_TYPE, SLOT))
				next_data = TYPE_CODE;
			else
				next_exc = EXC_BAD_ADDR;
		end else if (held.func == FC_READ_HOLD) begin
			if (hits(direct[15:0], OFS_HOLD_PROC, allocAddr))
				next_data = channelWord;
			else
				next_exc = EXC_BAD_ADDR;
		end else if (held.func == FC_READ_BITS) begin
			if (bitIdx < 16'h0008)
				next_data = {15'h0000, statusWord[8 + bitIdx[2:0]]};
			else
				next_exc = EXC_BAD_ADDR;
		end else begin
			// Writes and unknown functions touch nothing.
			next_exc = EXC_BAD_FUNC;
		end
	end

	// Answer register and ready flag, all from flip-flops. The answer
	// holds until the next one, so a slow master may still pick it up
	// after the valid pulse has gone.
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp      <= '0;
			rspValid <= 1'b0;
			reqReady <= 1'b1;
		end else begin
			rspValid <= state == ST_DECODE;
			reqReady <= next_state == ST_IDLE;
			if (state == ST_DECODE) begin
				rsp.data <= next_data;
				rsp.exc  <= next_exc;
			end
		end
	end

endmodule

// file: bench/cwp_checker.sv
// Port assertions for the current-input channel.
`timescale 1ns/1ps
module cwp_checker
	import cwp_pkg::*;
#(
	parameter int UPDATE_COUNT = 16
)(
	// Clock and reset.
	input wire logic              clk,
	input wire logic              rst,
	// Configuration.
	input wire logic              lineFaultEnable,
	input wire logic [MEAS_W-1:0] breakCode,
	input wire logic [MEAS_W-1:0] shortCode,
	input wire logic [15:0]       scaleBegin,
	input wire logic [15:0]       scaleEnd,
	// Bus and published word.
	input wire logic              reqValid,
	input wire logic              reqReady,
	input wire logic              rspValid,
	input wire logic [WORD_W-1:0] channelWord,
	input wire logic              publishPulse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic              inWin;
	logic [MEAS_W-1:0] meas;
	logic              seen;
	int                gap;

	// Status is only meaningful while the scaling sits in the window.
	assign inWin = scaleBegin >= SCALE_MIN && scaleEnd <= SCALE_MAX;
	assign meas  = channelWord[15:4];

	// Cycles since the last publish; the first gap after reset is skipped.
	always_ff @(posedge clk) begin
		if (rst || publishPulse)
			gap <= 1;
		else
			gap <= gap + 1;
		seen <= !rst && (seen || publishPulse);
	end

	sequence busy_s;
		!reqReady && !rspValid;
	endsequence
	// The answer comes one edge after taking, ready one edge later.
	sequence answer_s;
		busy_s ##1 (rspValid && !reqReady) ##1 (reqReady && !rspValid);
	endsequence

	answer_time_a: assert property (
		reqValid && reqReady |=> answer_s) else $error("late answer");
	answer_pulse_a: assert property (
		rspValid |=> !rspValid) else $error("answer too long");
	unused_bits_a: assert property (
		channelWord[3:2] == 2'b00) else $error("unused bits set");
	publish_only_a: assert property (
		$changed(channelWord) |-> ##[0:1] publishPulse)
		else $error("word changed off publish");
	publish_period_a: assert property (
		publishPulse && seen |-> gap == UPDATE_COUNT)
		else $error("publish period wrong");
	live_zero_a: assert property (
		publishPulse && inWin |-> channelWord[0] == (meas < LIVE_ZERO_CODE))
		else $error("live zero bit wrong");
	line_fault_a: assert property (
		publishPulse && inWin && lineFaultEnable
		|-> channelWord[1] == (meas < breakCode || meas > shortCode))
		else $error("line fault bit wrong");
	fault_off_a: assert property (
		publishPulse && !lineFaultEnable |-> !channelWord[1])
		else $error("fault bit while disabled");
	window_drop_a: assert property (
		publishPulse && !inWin |-> channelWord[1:0] == 2'b00)
		else $error("status kept outside window");
endmodule

bind cwp_current_input cwp_checker #(.UPDATE_COUNT(UPDATE_COUNT)) chk (
	.clk(clk), .rst(rst), .lineFaultEnable(lineFaultEnable),
	.breakCode(breakCode), .shortCode(shortCode), .scaleBegin(scaleBegin),
	.scaleEnd(scaleEnd), .reqValid(reqValid), .reqReady(reqReady),
	.rspValid(rspValid), .channelWord(channelWord),
	.publishPulse(publishPulse));

// file: bench/cwp_master_model.sv
// Behavioural bus master issuing one read at a time.
`timescale 1ns/1ps
module cwp_master_model
	import cwp_pkg::*;
(
	// Clock.
	input  wire logic     clk,
	// Request side.
	output cwp_req_s      req,
	output logic          reqValid,
	input  wire logic     reqReady,
	// Answer side.
	input  wire cwp_rsp_s rsp,
	input  wire logic     rspValid
);
	// Idle bus at time zero.
	initial begin
		req = '0;
		reqValid = 1'b0;
	end

	// Hold the request until an idle edge takes it, then wait for the
	// answer; word and bit reads alike are one unit each.
	task automatic read(input logic [7:0] f, input logic [15:0] a,
		input logic c, output cwp_rsp_s r);
		int n;
		@(negedge clk);
		req = '{f, a, c};
		reqValid = 1'b1;
		n = 0;
		while (reqReady !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		reqValid = 1'b0;
		// Inverted lines so a stale request can never be mistaken for live.
		req = ~req;
		while (rspValid !== 1'b1 && n < 16) begin
			@(negedge clk);
			n++;
		end
		r = rsp;
	endtask
endmodule

// file: bench/cwp_current_input_tb.sv
// Self-checking testbench for the current-input channel.
`timescale 1ns/1ps
module cwp_current_input_tb
	import cwp_pkg::*;
;
	localparam logic [15:0] TYPE = 16'h00A5; // Arbitrary type code.
	localparam logic [15:0] W    = 16'h0A23;

	logic              clk;
	logic              rst;
	logic [MEAS_W-1:0] sampleCode;
	logic              sampleValid;
	logic              lfEn;
	logic [15:0]       scaleBegin;
	logic [15:0]       scaleEnd;
	logic [MEAS_W-1:0] breakCode;
	logic [MEAS_W-1:0] shortCode;
	logic [15:0]       allocAddr;
	logic [15:0]       cfgEnd;
	logic [MEAS_W-1:0] cfgBreak;
	logic [MEAS_W-1:0] cfgShort;
	cwp_req_s          req;
	logic              reqValid;
	logic              reqReady;
	cwp_rsp_s          rsp;
	logic              rspValid;
	logic [WORD_W-1:0] channelWord;
	logic              publishPulse;
	cwp_rsp_s          r;
	int                miscompares;
	int                nChecks;
	int                cycles;

	cwp_current_input #(.UPDATE_COUNT(16), .SLOT(16'h0003),
		.TYPE_CODE(TYPE)) dut (
		.clk(clk), .rst(rst), .sampleCode(sampleCode),
		.sampleValid(sampleValid), .lineFaultEnable(lfEn),
		.breakCode(breakCode), .shortCode(shortCode),
		.scaleBegin(scaleBegin), .scaleEnd(scaleEnd),
		.allocAddr(allocAddr), .req(req), .reqValid(reqValid),
		.reqReady(reqReady), .rsp(rsp), .rspValid(rspValid),
		.channelWord(channelWord), .publishPulse(publishPulse));

	cwp_master_model m (.clk(clk), .req(req), .reqValid(reqValid),
		.reqReady(reqReady), .rsp(rsp), .rspValid(rspValid));

	task automatic report_and_stop();
		if (miscompares == 0 && nChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Plain numbers for address and expectations keep the calls short;
	// each is cut to its field width here on purpose.
	task automatic rd(input logic [7:0] f, input int a,
		input logic c, input int d, input int e);
		cwp_rsp_s x;
		m.read(f, 16'(a), c, x);
		check(x.data, 16'(d));
		check({8'h00, x.exc}, 16'(e));
	endtask

	// Bounded wait for the next publish, seen at a falling edge.
	task automatic wait_pub();
		int n;
		n = 0;
		@(negedge clk);
		while (publishPulse !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n == 40)
			miscompares++;
	endtask

	// New sample and setup just after a publish, so none straddles one.
	task automatic pack(input logic [11:0] code, input logic en,
		input logic [15:0] sb, input logic [15:0] exp);
		wait_pub();
		@(negedge clk);
		sampleCode = code;
		sampleValid = 1'b1;
		lfEn = en;
		scaleBegin = sb;
		scaleEnd = cfgEnd;
		breakCode = cfgBreak;
		shortCode = cfgShort;
		@(negedge clk);
		sampleValid = 1'b0;
		wait_pub();
		wait_pub();
		check(channelWord, exp);
		rd(FC_READ_INPUT, 16'h0005, 1'b0, exp, EXC_NONE);
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Cut a hang short well beyond the expected run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		rst = 1'b1;
		sampleCode = '0;
		sampleValid = 1'b0;
		lfEn = 1'b1;
		scaleBegin = SCALE_MIN;
		scaleEnd = SCALE_MAX;
		breakCode = BREAK_DEFAULT;
		shortCode = SHORT_DEFAULT;
		allocAddr = 16'h0005;
		cfgEnd = SCALE_MAX;
		cfgBreak = BREAK_DEFAULT;
		cfgShort = SHORT_DEFAULT;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		check(channelWord, 16'h0000);
		pack(12'h800, 1'b1, SCALE_MIN, 16'h8000);
		pack(12'hFFF, 1'b1, SCALE_MIN, 16'hFFF2);
		pack(12'h24E, 1'b1, SCALE_MIN, 16'h24E0);
		pack(12'h24D, 1'b1, SCALE_MIN, 16'h24D1);
		pack(12'h0A3, 1'b1, SCALE_MIN, 16'h0A31);
		pack(12'hD70, 1'b1, SCALE_MIN, 16'hD700);
		pack(12'hD71, 1'b1, SCALE_MIN, 16'hD712);
		pack(12'h0A2, 1'b1, SCALE_MIN, W);
		rd(FC_READ_INPUT, OFS_SLOT_PROC + 3, 1'b0, W, EXC_NONE);
		rd(FC_READ_INPUT, OFS_SLOT_STAT + 3, 1'b0, 16'h0300, 0);
		rd(FC_READ_INPUT, OFS_SLOT_TYPE + 3, 1'b0, TYPE, 0);
		rd(FC_READ_HOLD, OFS_HOLD_PROC + 5, 1'b0, W, 0);
		rd(FC_READ_BITS, OFS_STAT_BITS + 24, 1'b0, 1, 0);
		rd(FC_READ_BITS, OFS_STAT_BITS + 25, 1'b0, 1, 0);
		rd(FC_READ_BITS, OFS_STAT_BITS + 26, 1'b0, 0, 0);
		rd(FC_READ_INPUT, CONV_INPUT + 5, 1'b1, W, 0);
		rd(FC_READ_INPUT, CONV_SLOT_PROC + 3, 1'b1, W, 0);
		rd(FC_READ_INPUT, CONV_SLOT_STAT + 3, 1'b1, 16'h0300, 0);
		rd(FC_READ_INPUT, CONV_SLOT_TYPE + 3, 1'b1, TYPE, 0);
		rd(FC_READ_HOLD, CONV_HOLD_PROC + 5, 1'b1, W, 0);
		rd(FC_READ_BITS, CONV_STAT_BITS + 25, 1'b1, 1, 0);
		rd(FC_READ_INPUT, OFS_SLOT_PROC + 4, 1'b0, 0, EXC_BAD_ADDR);
		m.read(8'h06, 16'h0005, 1'b0, r);
		check({8'h00, r.exc}, {8'h00, EXC_BAD_FUNC});
		rd(FC_READ_INPUT, 16'h0005, 1'b0, W, EXC_NONE);
		rd(FC_READ_HOLD, CONV_HOLD_PROC - 1, 1'b1, 0, EXC_BAD_ADDR);
		rd(FC_READ_BITS, OFS_STAT_BITS + 32, 1'b0, 0, EXC_BAD_ADDR);
		allocAddr = 16'h0020;
		rd(FC_READ_INPUT, 16'h0020, 1'b0, W, EXC_NONE);
		rd(FC_READ_HOLD, OFS_HOLD_PROC + 32, 1'b0, W, EXC_NONE);
		rd(FC_READ_INPUT, 16'h0005, 1'b0, 0, EXC_BAD_ADDR);
		allocAddr = 16'h0005;
		pack(12'h0A2, 1'b0, SCALE_MIN, 16'h0A21);
		pack(12'h0A2, 1'b1, 16'h270F, 16'h0A20);
		cfgBreak = 12'h400;
		cfgShort = 12'hC00;
		pack(12'h3FF, 1'b1, SCALE_MIN, 16'h3FF2);
		pack(12'hC01, 1'b1, SCALE_MIN, 16'hC012);
		pack(12'hC00, 1'b1, SCALE_MIN, 16'hC000);
		cfgEnd = 16'hC351;
		pack(12'h0A2, 1'b1, SCALE_MIN, 16'h0A20);
		report_and_stop();
	end
endmodule
